// ---- logic/rlp_pkg.sv ----
// Purpose: Shared constants and types of the reset and low-power controller
// Assumes: One internal bus cycle equals one clk_i cycle (100 MHz)
// Notes:   Offsets are byte addresses on the Avalon-MM slave
`default_nettype none
package rlp_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [15:0] RLP_WDOG_OFS     = 16'h1ff0;
	localparam logic [15:0] RLP_USB_IR0_OFS  = 16'h1f00;
	localparam logic [15:0] RLP_CAUSE_OFS    = 16'h1f04;
	localparam logic [15:0] RLP_MODE_OFS     = 16'h1f08;
	localparam logic [15:0] RLP_RESET_VECTOR = 16'h1ffe;
	localparam int          RLP_WDOG_CLR_BIT = 0;
	localparam int          RLP_USB_RST_BIT  = 0;
	localparam int          RLP_MODE_RET_BIT = 6;
	// Cause bits: por, pin, watchdog, low voltage, illegal fetch, usb
	localparam int          RLP_C_POR        = 0;
	localparam int          RLP_C_PIN        = 1;
	localparam int          RLP_C_WDOG       = 2;
	localparam int          RLP_C_LVR        = 3;
	localparam int          RLP_C_ILL        = 4;
	localparam int          RLP_C_USB        = 5;
	localparam logic [5:0]  RLP_CAUSE_RST    = 6'h01;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          RLP_CLK_MHZ      = 100;
	localparam logic [11:0] RLP_STAB_SHORT   = 12'h0e0;
	localparam logic [11:0] RLP_STAB_LONG    = 12'hfe0;
	// Least pin low time in tenths of an internal cycle
	localparam int          RLP_PIN_LOW_X10  = 15;
	localparam int          RLP_PIN_QUAL_CYC = (RLP_PIN_LOW_X10 + 9) / 10;
	localparam logic [2:0]  RLP_PD_MIN_CYC   = 3'h4;
	localparam logic [1:0]  RLP_PD_GAP_CYC   = 2'h3;
	localparam int          RLP_SE0_MIN_BITS = 4;
	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		RLP_ST_STAB = 6'h01,
		RLP_ST_HOLD = 6'h02,
		RLP_ST_RUN  = 6'h04,
		RLP_ST_WAIT = 6'h08,
		RLP_ST_STOP = 6'h10,
		RLP_ST_WAKE = 6'h20
	} rlp_state_e;
endpackage : rlp_pkg
`default_nettype wire

// ---- logic/rlp_sync.sv ----
// Purpose: Two-flop synchroniser for asynchronous level inputs
// Assumes: Inputs are levels, slower than clk_i
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module rlp_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} rlp_sync_s;

	rlp_sync_s q_r;
	rlp_sync_s q_nxt;

	always_comb begin
		q_nxt    = q_r;
		q_nxt.s1 = async_i;
		q_nxt.s2 = q_r.s1;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q_r <= {RST_VAL, RST_VAL};
		end else begin
			q_r <= q_nxt;
		end
	end

	assign sync_o = q_r.s2;
endmodule : rlp_sync
`default_nettype wire

// ---- logic/rlp_wdog.sv ----
// Purpose: Watchdog period counter
// Assumes: clear_i restarts the period, run_i gates counting
// Notes:   timeout_o stays high until cleared
`timescale 1ns/1ps
`default_nettype none
module rlp_wdog #(
	parameter int PERIOD = 16384
) (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic run_i,
	input  wire logic clear_i,
	output logic      timeout_o
);
	localparam int CW = $clog2(PERIOD);
	localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tmo;
	} rlp_wdog_s;

	rlp_wdog_s q_r;
	rlp_wdog_s q_nxt;

	always_comb begin
		q_nxt = q_r;
		if (clear_i) begin
			q_nxt.cnt = '0;
			q_nxt.tmo = 1'b0;
		end else if (run_i && !q_r.tmo) begin
			if (q_r.cnt == LAST) begin
				q_nxt.tmo = 1'b1;
			end else begin
				q_nxt.cnt = q_r.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign timeout_o = q_r.tmo;
endmodule : rlp_wdog
`default_nettype wire

// ---- logic/rlp_top.sv ----
// Purpose: Reset merging, reset pin pulldown and stop/wait sequencing
// Assumes: nrst_i is the power-on reset; CPU signals share clk_i
// Notes:   Registers on Avalon-MM, one wait state per access
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - Six causes reset: power-up, pin, watchdog, low voltage, illegal fetch, USB.
// R2 - Reset stops CPU at once, inits control bits, requests vector load.
// R3 - After oscillator start, hold reset 224 or 4064 cycles by option.
// R4 - Pin still low after the delay keeps reset until pin rises.
// R5 - Any other active source after the delay keeps reset until all end.
// R6 - Pin low for 1.5 cycles asserts internal reset to CPU and peripherals.
// R7 - Watchdog, low voltage, illegal fetch pull pin low, at least 4 cycles.
// R8 - No pulldown while the pin is already pulled low from outside.
// R9 - Power-on reset never drives the pin pulldown.
// R10 - SE0 for 4 bit times sets USB reset flag and resets.
// R11 - Enabled watchdog timing out causes a reset.
// R12 - Writing zero to watchdog bit 0 restarts the period; one is ignored.
// R13 - Watchdog register reads zero; clear bit is write-only.
// R14 - Enabled low-voltage detect resets while supply is low.
// R15 - Opcode fetch outside ROM and RAM causes a reset.
// R16 - Stop switches oscillator off and halts processing, state kept.
// R17 - Stop or wait clears interrupt mask and sets external interrupt enable.
// R18 - Stop ends on external or resume interrupt, pin, USB or LOW_VOLTAGE_RESET reset.
// R19 - Leaving stop restarts oscillator and waits the stabilisation delay.
// R20 - Wait halts CPU clock; state kept.
// R21 - Wait ends on external, USB, timer, MULTI_FUNCTION_TIMER interrupt or a reset.
// R22 - Retention mode only without low-voltage reset; no execution.
// R23 - Every reset fetches the vector at 1FFE/1FFF and sets the mask.
// R24 - Pin is synchronised and qualified over consecutive low samples.
// R25 - Outside keeps the pin low throughout retention mode.
module rlp_top #(
	parameter bit LONG_STAB    = 1'b1,
	parameter bit WDOG_EN      = 1'b1,
	parameter bit LVR_EN       = 1'b1,
	parameter int USB_BIT_CYC  = 67,
	parameter int WDOG_PERIOD  = 16384
) (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic [15:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        rst_pin_i,
	output logic             rst_pin_o,
	output logic             rst_pin_oe_n_o,
	input  wire logic        low_volt_i,
	input  wire logic        usb_se0_i,
	input  wire logic        ext_irq_i,
	input  wire logic        usb_resume_irq_i,
	input  wire logic        usb_irq_i,
	input  wire logic        timer1_irq_i,
	input  wire logic        mft_irq_i,
	input  wire logic        illegal_fetch_i,
	input  wire logic        stop_exec_i,
	input  wire logic        wait_exec_i,
	output logic             sys_rst_o,
	output logic             osc_en_o,
	output logic             cpu_clk_en_o,
	output logic             vec_fetch_o,
	output logic             set_ibit_o,
	output logic             clr_ibit_o,
	output logic             set_ext_int_enable_bit_o,
	output logic             retention_o,
	output logic             usb_rst_flag_o
);
	import rlp_pkg::*;

	// ----------------------------------------------------------------
	// Constants and state
	// ----------------------------------------------------------------
	localparam int SE0_CYC = RLP_SE0_MIN_BITS * USB_BIT_CYC;
	localparam int SW = $clog2(SE0_CYC + 1);
	localparam logic [SW-1:0] SE0_MAX = SW'(SE0_CYC);
	localparam logic [1:0] PIN_QUAL = 2'(RLP_PIN_QUAL_CYC);
	localparam logic [11:0] STAB_LAST = (LONG_STAB ? RLP_STAB_LONG : RLP_STAB_SHORT) - 12'h001;

	typedef struct packed {
		rlp_state_e    state;
		logic [11:0]   stab_cnt;
		logic [SW-1:0] se0_cnt;
		logic [1:0]    pin_cnt;
		logic [2:0]    pd_cnt;
		logic          pd_oe_n;
		logic [1:0]    pd_gap;
		logic          sys_rst;
		logic          osc_en;
		logic          cpu_clk_en;
		logic          vec_fetch;
		logic          set_ibit;
		logic          clr_ibit;
		logic          set_ext_int_enable_bit;
		logic          ret_mode;
		logic          usb_flag;
		logic [5:0]    cause;
		logic          waitreq;
		logic [31:0]   rdata;
		logic          wdog_kick;
	} rlp_top_s;

	rlp_top_s q_r;
	rlp_top_s q_nxt;

	logic [3:0] sync_s;
	logic       pin_s;
	logic       lv_s;
	logic       se0_s;
	logic       eirq_s;
	logic       wdog_tmo;
	logic       wdog_run;
	logic       wdog_clr;

	// ----------------------------------------------------------------
	// Input synchronisers and watchdog
	// ----------------------------------------------------------------
	rlp_sync #(
		.WIDTH   (4),
		.RST_VAL (4'h1)
	) u_sync (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.async_i ({ext_irq_i, usb_se0_i, low_volt_i, rst_pin_i}), // R24
		.sync_o  (sync_s)
	);

	assign pin_s  = sync_s[0];
	assign lv_s   = sync_s[1];
	assign se0_s  = sync_s[2];
	assign eirq_s = sync_s[3];

	assign wdog_run = WDOG_EN && !q_r.sys_rst && (q_r.state == RLP_ST_RUN || q_r.state == RLP_ST_WAIT);
	assign wdog_clr = q_r.wdog_kick || q_r.sys_rst; // R12 R13

	rlp_wdog #(
		.PERIOD    (WDOG_PERIOD)
	) u_wdog (
		.clk_i     (clk_i),
		.nrst_i    (nrst_i),
		.run_i     (wdog_run),
		.clear_i   (wdog_clr),
		.timeout_o (wdog_tmo)
	);

	// ----------------------------------------------------------------
	// Reset sources
	// ----------------------------------------------------------------
	logic pin_ext_low;
	logic pin_src;
	logic usb_src;
	logic wdog_src;
	logic lvr_src;
	logic ill_src;
	logic pd_req;
	logic any_src;
	logic stop_rst;
	logic stop_wake;
	logic wait_wake;
	logic req;
	logic hit_wdog;
	logic hit_usb;
	logic hit_cause;
	logic hit_mode;

	// Own pulldown and its release tail must not look like an outside reset
	assign pin_ext_low = !pin_s && q_r.pd_oe_n && q_r.pd_gap == 2'h0; // R8
	assign pin_src  = q_r.pin_cnt == PIN_QUAL; // R6 R24
	assign usb_src  = q_r.se0_cnt == SE0_MAX; // R10
	assign wdog_src = WDOG_EN && wdog_tmo; // R11
	assign lvr_src  = LVR_EN && lv_s; // R14
	assign ill_src  = illegal_fetch_i && q_r.cpu_clk_en; // R15
	assign pd_req   = wdog_src || lvr_src || ill_src; // R7 R9
	assign any_src  = pin_src || usb_src || pd_req; // R1
	assign stop_rst  = pin_src || usb_src || lvr_src; // R18
	assign stop_wake = eirq_s || usb_resume_irq_i; // R18
	assign wait_wake = eirq_s || usb_irq_i || timer1_irq_i || mft_irq_i; // R21

	assign req       = avs_read_i || avs_write_i;
	assign hit_wdog  = avs_address_i == RLP_WDOG_OFS;
	assign hit_usb   = avs_address_i == RLP_USB_IR0_OFS;
	assign hit_cause = avs_address_i == RLP_CAUSE_OFS;
	assign hit_mode  = avs_address_i == RLP_MODE_OFS;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		q_nxt           = q_r;
		q_nxt.vec_fetch = 1'b0;
		q_nxt.set_ibit  = 1'b0;
		q_nxt.clr_ibit  = 1'b0;
		q_nxt.set_ext_int_enable_bit  = 1'b0;
		q_nxt.wdog_kick = 1'b0;

		// Pin qualification over consecutive low samples
		if (!pin_ext_low) begin
			q_nxt.pin_cnt = 2'h0;
		end else if (q_r.pin_cnt != PIN_QUAL) begin
			q_nxt.pin_cnt = q_r.pin_cnt + 2'h1; // R24
		end

		// SE0 duration on the upstream port
		if (!se0_s) begin
			q_nxt.se0_cnt = '0;
		end else if (q_r.se0_cnt != SE0_MAX) begin
			q_nxt.se0_cnt = q_r.se0_cnt + 1'b1; // R10
		end

		// Reset pin pulldown
		if (!q_r.pd_oe_n) begin
			if (q_r.pd_cnt != 3'h0) begin
				q_nxt.pd_cnt = q_r.pd_cnt - 3'h1;
			end else if (!pd_req) begin
				q_nxt.pd_oe_n = 1'b1; // R7
				q_nxt.pd_gap  = RLP_PD_GAP_CYC;
			end
		end else begin
			if (q_r.pd_gap != 2'h0) begin
				q_nxt.pd_gap = q_r.pd_gap - 2'h1;
			end
			if (pd_req && pin_s) begin
				q_nxt.pd_oe_n = 1'b0; // R7 R8 R9
				q_nxt.pd_cnt  = RLP_PD_MIN_CYC - 3'h1;
			end
		end

		// Sequencer
		unique case (q_r.state)
			RLP_ST_STAB: begin
				q_nxt.sys_rst  = 1'b1;
				q_nxt.osc_en   = 1'b1;
				q_nxt.stab_cnt = q_r.stab_cnt + 12'h001;
				if (q_r.stab_cnt == STAB_LAST) begin
					q_nxt.state = RLP_ST_HOLD; // R3
				end
			end
			RLP_ST_HOLD: begin
				if (!any_src && q_r.pd_oe_n) begin
					q_nxt.state      = RLP_ST_RUN; // R4 R5
					q_nxt.sys_rst    = 1'b0;
					q_nxt.cpu_clk_en = 1'b1;
					q_nxt.vec_fetch  = 1'b1; // R2 R23
					q_nxt.set_ibit   = 1'b1; // R23
				end
			end
			RLP_ST_RUN: begin
				if (any_src) begin
					q_nxt.state      = RLP_ST_HOLD;
					q_nxt.sys_rst    = 1'b1; // R2
					q_nxt.cpu_clk_en = 1'b0;
				end else if (stop_exec_i) begin
					q_nxt.state      = RLP_ST_STOP;
					q_nxt.osc_en     = 1'b0; // R16
					q_nxt.cpu_clk_en = 1'b0;
					q_nxt.clr_ibit   = 1'b1; // R17
					q_nxt.set_ext_int_enable_bit   = 1'b1;
				end else if (wait_exec_i) begin
					q_nxt.state      = RLP_ST_WAIT;
					q_nxt.cpu_clk_en = 1'b0; // R20
					q_nxt.clr_ibit   = 1'b1; // R17
					q_nxt.set_ext_int_enable_bit   = 1'b1;
				end
			end
			RLP_ST_WAIT: begin
				if (any_src) begin
					q_nxt.state   = RLP_ST_HOLD; // R21
					q_nxt.sys_rst = 1'b1;
				end else if (wait_wake) begin
					q_nxt.state      = RLP_ST_RUN; // R21
					q_nxt.cpu_clk_en = 1'b1;
				end
			end
			RLP_ST_STOP: begin
				if (stop_rst) begin
					q_nxt.state    = RLP_ST_STAB; // R18 R19
					q_nxt.osc_en   = 1'b1;
					q_nxt.sys_rst  = 1'b1;
					q_nxt.stab_cnt = 12'h000;
				end else if (stop_wake) begin
					q_nxt.state    = RLP_ST_WAKE; // R18 R19
					q_nxt.osc_en   = 1'b1;
					q_nxt.stab_cnt = 12'h000;
				end
			end
			RLP_ST_WAKE: begin
				q_nxt.stab_cnt = q_r.stab_cnt + 12'h001;
				if (stop_rst) begin
					q_nxt.state   = RLP_ST_STAB;
					q_nxt.sys_rst = 1'b1;
				end else if (q_r.stab_cnt == STAB_LAST) begin
					q_nxt.state      = RLP_ST_RUN; // R19
					q_nxt.cpu_clk_en = 1'b1;
				end
			end
			default: begin
				q_nxt.state    = RLP_ST_STAB;
				q_nxt.sys_rst  = 1'b1;
				q_nxt.stab_cnt = 12'h000;
			end
		endcase

		// Retention: pin held low from outside with no low-voltage reset
		q_nxt.ret_mode = !LVR_EN && pin_src && q_r.sys_rst; // R22 R25

		// Register bus, write side
		if (avs_write_i && !q_r.waitreq) begin
			if (hit_wdog && avs_byteenable_i[0]) begin
				q_nxt.wdog_kick = !avs_writedata_i[RLP_WDOG_CLR_BIT]; // R12
			end
			if (hit_usb && avs_byteenable_i[0] && avs_writedata_i[RLP_USB_RST_BIT]) begin
				q_nxt.usb_flag = 1'b0;
			end
			if (hit_cause && avs_byteenable_i[0]) begin
				q_nxt.cause = q_r.cause & ~avs_writedata_i[5:0];
			end
		end

		// Hardware set wins over a clear in the same cycle
		if (usb_src) begin
			q_nxt.usb_flag = 1'b1; // R10
		end
		q_nxt.cause[RLP_C_PIN]  = q_nxt.cause[RLP_C_PIN] | pin_src;
		q_nxt.cause[RLP_C_WDOG] = q_nxt.cause[RLP_C_WDOG] | wdog_src;
		q_nxt.cause[RLP_C_LVR]  = q_nxt.cause[RLP_C_LVR] | lvr_src;
		q_nxt.cause[RLP_C_ILL]  = q_nxt.cause[RLP_C_ILL] | ill_src;
		q_nxt.cause[RLP_C_USB]  = q_nxt.cause[RLP_C_USB] | usb_src;

		// Register bus, read side and wait state
		q_nxt.waitreq = !(req && q_r.waitreq);
		if (avs_read_i && q_r.waitreq) begin
			q_nxt.rdata = 32'h0000_0000; // R13
			if (hit_usb) begin
				q_nxt.rdata[RLP_USB_RST_BIT] = q_r.usb_flag;
			end
			if (hit_cause) begin
				q_nxt.rdata[5:0] = q_r.cause;
			end
			if (hit_mode) begin
				q_nxt.rdata[5:0]              = q_r.state;
				q_nxt.rdata[RLP_MODE_RET_BIT] = q_r.ret_mode;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q_r            <= '0;
			q_r.state      <= RLP_ST_STAB; // R1 R9
			q_r.sys_rst    <= 1'b1;
			q_r.osc_en     <= 1'b1;
			q_r.pd_oe_n    <= 1'b1;
			q_r.cause      <= RLP_CAUSE_RST;
			q_r.waitreq    <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign avs_readdata_o    = q_r.rdata;
	assign avs_waitrequest_o = q_r.waitreq;
	assign rst_pin_o         = 1'b0;
	assign rst_pin_oe_n_o    = q_r.pd_oe_n;
	assign sys_rst_o         = q_r.sys_rst;
	assign osc_en_o          = q_r.osc_en;
	assign cpu_clk_en_o      = q_r.cpu_clk_en;
	assign vec_fetch_o       = q_r.vec_fetch;
	assign set_ibit_o        = q_r.set_ibit;
	assign clr_ibit_o        = q_r.clr_ibit;
	assign set_ext_int_enable_bit_o        = q_r.set_ext_int_enable_bit;
	assign retention_o       = q_r.ret_mode;
	assign usb_rst_flag_o    = q_r.usb_flag;
endmodule : rlp_top
`default_nettype wire

// ---- sim/rlp_top_monitor.sv ----
// Purpose: Concurrent checks on the reset and low-power controller ports
// Assumes: One clock domain, nrst_i is the power-on reset
// Notes:   Bound into every rlp_top instance
`timescale 1ns/1ps
`default_nettype none
module rlp_top_monitor #(
	parameter bit LVR_EN = 1'b1
) (
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic [15:0] avs_address_i,
	input wire logic        avs_read_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic        rst_pin_i,
	input wire logic        rst_pin_oe_n_o,
	input wire logic        low_volt_i,
	input wire logic        illegal_fetch_i,
	input wire logic        stop_exec_i,
	input wire logic        wait_exec_i,
	input wire logic        sys_rst_o,
	input wire logic        osc_en_o,
	input wire logic        cpu_clk_en_o,
	input wire logic        vec_fetch_o,
	input wire logic        set_ibit_o,
	input wire logic        clr_ibit_o,
	input wire logic        set_ext_int_enable_bit_o,
	input wire logic        usb_rst_flag_o
);
	import rlp_pkg::*;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_pd_len;
		$fell(rst_pin_oe_n_o) |-> !rst_pin_oe_n_o [*4];
	endproperty
	a_pd_len: assert property (p_pd_len) else $error("pulldown too short");
	property p_pd_rst;
		!rst_pin_oe_n_o |-> sys_rst_o;
	endproperty
	a_pd_rst: assert property (p_pd_rst) else $error("pulldown outside reset");
	property p_ill;
		illegal_fetch_i && rst_pin_i && cpu_clk_en_o && !sys_rst_o |=> sys_rst_o && !rst_pin_oe_n_o;
	endproperty
	a_ill: assert property (p_ill) else $error("illegal fetch missed");
	property p_vec;
		$fell(sys_rst_o) |-> vec_fetch_o && set_ibit_o;
	endproperty
	a_vec: assert property (p_vec) else $error("no vector fetch");
	property p_vec_only;
		vec_fetch_o |-> $fell(sys_rst_o);
	endproperty
	a_vec_only: assert property (p_vec_only) else $error("stray vector fetch");
	property p_stop;
		stop_exec_i && !illegal_fetch_i && cpu_clk_en_o && !sys_rst_o
			|=> !osc_en_o && !cpu_clk_en_o && clr_ibit_o && set_ext_int_enable_bit_o;
	endproperty
	a_stop: assert property (p_stop) else $error("stop entry wrong");
	property p_wait;
		wait_exec_i && !stop_exec_i && !illegal_fetch_i && cpu_clk_en_o && !sys_rst_o
			|=> osc_en_o && !cpu_clk_en_o && clr_ibit_o && set_ext_int_enable_bit_o;
	endproperty
	a_wait: assert property (p_wait) else $error("wait entry wrong");
	property p_osc;
		!osc_en_o |-> !cpu_clk_en_o;
	endproperty
	a_osc: assert property (p_osc) else $error("cpu runs without oscillator");
	property p_pin;
		!rst_pin_i [*7] |-> sys_rst_o;
	endproperty
	a_pin: assert property (p_pin) else $error("pin low without reset");
	property p_lv;
		(LVR_EN && low_volt_i) [*5] |-> sys_rst_o;
	endproperty
	a_lv: assert property (p_lv) else $error("low supply without reset");
	property p_wd_rd;
		!avs_waitrequest_o && avs_read_i && avs_address_i == RLP_WDOG_OFS |-> avs_readdata_o == 32'h0;
	endproperty
	a_wd_rd: assert property (p_wd_rd) else $error("watchdog read not zero");
	property p_usb;
		$rose(usb_rst_flag_o) |-> ##[0:2] sys_rst_o;
	endproperty
	a_usb: assert property (p_usb) else $error("usb flag without reset");
	c_pulldown: cover property ($fell(rst_pin_oe_n_o));
	c_stop: cover property (!osc_en_o);
	c_usb: cover property ($rose(usb_rst_flag_o));
endmodule : rlp_top_monitor
bind rlp_top rlp_top_monitor #(.LVR_EN(LVR_EN)) u_mon (.*);
`default_nettype wire

// ---- sim/rlp_pin_model.sv ----
// Purpose: External reset circuitry on the open-drain reset pin
// Assumes: Pin has a pull-up; either party may sink it
// Notes:   ext_low_i is held by the bench for many cycles
`timescale 1ns/1ps
`default_nettype none
module rlp_pin_model (
	input  wire logic ext_low_i,
	input  wire logic oe_n_i,
	output logic      pin_o
);
	// Pull-up level unless someone sinks the line
	assign pin_o = !(ext_low_i || !oe_n_i);
endmodule : rlp_pin_model
`default_nettype wire

// ---- sim/rlp_top_test.sv ----
// Purpose: Self-checking bench of the reset and low-power controller
// Assumes: Short stabilisation option, short watchdog and usb bit time
// Notes:   Each test after t_por starts with the device running; t_por starts in reset
`timescale 1ns/1ps
`default_nettype none
module rlp_top_test;
	import rlp_pkg::*;
	logic        clk_i, nrst_i, avs_read_i, avs_write_i, rst_pin_i, low_volt_i, usb_se0_i, ext_irq_i;
	logic        timer1_irq_i, illegal_fetch_i, stop_exec_i, wait_exec_i, ext_low, usb_resume_irq_i, usb_irq_i;
	logic        mft_irq_i, rst_pin_o, retention_o;
	logic [15:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, q;
	logic [3:0]  avs_byteenable_i;
	logic        avs_waitrequest_o, rst_pin_oe_n_o, sys_rst_o, osc_en_o, cpu_clk_en_o, vec_fetch_o;
	logic        set_ibit_o, clr_ibit_o, set_ext_int_enable_bit_o, usb_rst_flag_o;
	int          bad_count, samples_checked, n, pd, k;
	rlp_top #(.LONG_STAB(1'b0), .USB_BIT_CYC(4), .WDOG_PERIOD(600)) DUT (.*);
	rlp_pin_model u_pin (.ext_low_i(ext_low), .oe_n_i(rst_pin_oe_n_o), .pin_o(rst_pin_i));
	initial begin
		clk_i = 0;
		forever #5 clk_i = ~clk_i;
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input bit w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_read_i <= !w;
		avs_write_i <= w;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_read_i <= 0;
		avs_write_i <= 0;
	endtask : bus
	// Cycles until reset ends, and cycles with the pulldown on
	task automatic run_wait();
		n = 0;
		pd = 0;
		do begin
			@(posedge clk_i);
			n++;
			pd += (rst_pin_oe_n_o === 1'b0);
		end while (sys_rst_o !== 1'b0);
	endtask : run_wait
	task automatic cause(input logic [31:0] e);
		bus(0, RLP_CAUSE_OFS, 0);
		chk("cause", e, q);
		bus(1, RLP_CAUSE_OFS, 32'h3f);
	endtask : cause
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	task automatic t_por();
		run_wait();
		chk("por delay", 1, n >= 224 && n < 240);
		chk("por pulldown", 0, pd);
		chk("vector fetch", 1, vec_fetch_o);
		chk("mask set", 1, set_ibit_o);
		bus(1, RLP_WDOG_OFS, 32'hff);
		bus(0, RLP_WDOG_OFS, 0);
		chk("watchdog read", 0, q);
		bus(0, RLP_MODE_OFS, 0);
		chk("mode", 32'(RLP_ST_RUN), q);
		bus(0, 16'h0010, 0);
		chk("unmapped", 0, q);
		cause(32'h1);
		$display("por test done");
	endtask : t_por
	task automatic t_ill();
		@(posedge clk_i);
		illegal_fetch_i <= 1;
		@(posedge clk_i);
		illegal_fetch_i <= 0;
		run_wait();
		chk("illegal pulldown", 4, pd);
		chk("pin drive level", 0, rst_pin_o);
		chk("vector fetch", 1, vec_fetch_o);
		cause(32'h10);
		$display("illegal fetch test done");
	endtask : t_ill
	task automatic t_pin();
		ext_low <= 1;
		repeat (40) @(posedge clk_i);
		chk("pin reset", 1, sys_rst_o);
		chk("no pulldown", 1, rst_pin_oe_n_o);
		chk("retention", 0, retention_o);
		ext_low <= 0;
		run_wait();
		chk("pin pulldown", 0, pd);
		cause(32'h2);
		$display("pin test done");
	endtask : t_pin
	task automatic t_lowv();
		low_volt_i <= 1;
		repeat (300) @(posedge clk_i);
		chk("supply reset", 1, sys_rst_o);
		chk("pulldown held", 0, rst_pin_oe_n_o);
		low_volt_i <= 0;
		run_wait();
		cause(32'h8);
		$display("supply test done");
	endtask : t_lowv
	task automatic t_wdog();
		bus(1, RLP_WDOG_OFS, 0);
		repeat (400) @(posedge clk_i);
		bus(1, RLP_WDOG_OFS, 0);
		repeat (400) @(posedge clk_i);
		chk("kicked", 0, sys_rst_o);
		bus(1, RLP_WDOG_OFS, 1);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (sys_rst_o !== 1'b1);
		// Pulldown starts with reset, one cycle before run_wait counts
		k = (rst_pin_oe_n_o === 1'b0);
		chk("one ignored", 1, n < 400);
		run_wait();
		chk("wdog pulldown", 32'(RLP_PD_MIN_CYC), pd + k);
		cause(32'h4);
		$display("watchdog test done");
	endtask : t_wdog
	task automatic t_stop();
		for (int i = 0; i < 2; i++) begin
			bus(1, RLP_WDOG_OFS, 0);
			@(posedge clk_i);
			stop_exec_i <= 1;
			@(posedge clk_i);
			stop_exec_i <= 0;
			@(posedge clk_i);
			chk("stop osc", 0, osc_en_o);
			chk("stop mask", 1, clr_ibit_o);
			chk("stop irq enable", 1, set_ext_int_enable_bit_o);
			repeat (20) @(posedge clk_i);
			chk("stop held", 0, cpu_clk_en_o);
			case (i)
				0: ext_irq_i <= 1;
				default: usb_resume_irq_i <= 1;
			endcase
			n = 0;
			do begin
				@(posedge clk_i);
				n++;
			end while (cpu_clk_en_o !== 1'b1);
			{ext_irq_i, usb_resume_irq_i} <= '0;
			chk("wake delay", 1, n >= 224 && n < 240);
			chk("wake no reset", 0, sys_rst_o);
		end
		$display("stop test done");
	endtask : t_stop
	task automatic t_wait();
		for (int i = 0; i < 3; i++) begin
			bus(1, RLP_WDOG_OFS, 0);
			@(posedge clk_i);
			wait_exec_i <= 1;
			@(posedge clk_i);
			wait_exec_i <= 0;
			@(posedge clk_i);
			chk("wait osc", 1, osc_en_o);
			chk("wait mask", 1, clr_ibit_o);
			chk("wait irq enable", 1, set_ext_int_enable_bit_o);
			repeat (20) @(posedge clk_i);
			chk("wait held", 0, cpu_clk_en_o);
			case (i)
				0: timer1_irq_i <= 1;
				1: mft_irq_i <= 1;
				default: usb_irq_i <= 1;
			endcase
			repeat (2) @(posedge clk_i);
			{timer1_irq_i, mft_irq_i, usb_irq_i} <= '0;
			chk("wait exit", 1, cpu_clk_en_o);
		end
		$display("wait test done");
	endtask : t_wait
	task automatic t_usb();
		usb_se0_i <= 1;
		repeat (10) @(posedge clk_i);
		usb_se0_i <= 0;
		repeat (4) @(posedge clk_i);
		chk("short se0", 0, usb_rst_flag_o);
		usb_se0_i <= 1;
		repeat (30) @(posedge clk_i);
		chk("usb flag", 1, usb_rst_flag_o);
		chk("usb reset", 1, sys_rst_o);
		usb_se0_i <= 0;
		run_wait();
		avs_byteenable_i <= 4'h0;
		bus(1, RLP_USB_IR0_OFS, 1);
		avs_byteenable_i <= 4'hf;
		bus(0, RLP_USB_IR0_OFS, 0);
		chk("flag kept", 1, q);
		bus(1, RLP_USB_IR0_OFS, 1);
		bus(0, RLP_USB_IR0_OFS, 0);
		chk("flag cleared", 0, q);
		$display("usb test done");
	endtask : t_usb
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		{avs_read_i, avs_write_i, ext_low, low_volt_i, usb_se0_i, ext_irq_i} = '0;
		{timer1_irq_i, illegal_fetch_i, stop_exec_i, wait_exec_i} = '0;
		{usb_resume_irq_i, usb_irq_i, mft_irq_i} = '0;
		avs_address_i = '0;
		avs_writedata_i = '0;
		avs_byteenable_i = 4'hf;
		bad_count = 0;
		samples_checked = 0;
		nrst_i = 0;
		repeat (16) @(posedge clk_i);
		nrst_i <= 1;
		t_por();
		t_ill();
		t_pin();
		t_lowv();
		t_wdog();
		t_stop();
		t_wait();
		t_usb();
		complete_run();
	end
	initial begin
		#200000;
		bad_count++;
		complete_run();
	end
endmodule : rlp_top_test
`default_nettype wire
